/* logic/sfp_pkg.sv */
// constants, carrier types and decode helpers of the flash array protection block
//
// What this block does
// - program only clears bits to 0; erase sets them back to 1
// - erase by subsector, sector or whole array; never by page
// - 4 MiB array: 64 sectors, 1024 subsectors, 16384 pages, from address 0
// - 64-byte one-time area kept apart from the main array addresses
// - modifying command runs only if selected clock count is whole bytes
// - modifying command needs the write-enable latch set beforehand by the host
// - sector write-lock set refuses program and erase in that sector
// - sector lock-down set freezes its write-lock until reset
// - lock write ignored while the sector's lock-down is set
// - top mode: codes 1-6 guard highest 1..32 sectors, 7 all, 0 none
// - bottom mode: codes 1-6 guard lowest 1..32 sectors, 7 all, 0 none
// - only clock modes idle-low and idle-high are supported
// - inputs taken on rising clock edges, outputs change after falling edges
// - serial output driven only while selected, otherwise released
// - write-protect low with status bit 7 set keeps the block-protect region locked as set
// - status bit 7 with write-protect pin decides status write acceptance
package sfp_pkg;
    localparam int ADDR_W    = 22;
    localparam int SEC_W     = 6;
    localparam int SEC_LSB   = 16;
    localparam int OTP_AW    = 6;
    localparam int PAGE_MAX  = 256;
    localparam int OTP_BYTES = 64;

    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_OTPP = 8'h42;
    localparam logic [7:0] OP_SSE  = 8'h20;
    localparam logic [7:0] OP_SE   = 8'hd8;
    localparam logic [7:0] OP_BE   = 8'hc7;
    localparam logic [7:0] OP_WRLR = 8'he5;

    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_RESULT = 8'h08;
    localparam logic [7:0] A_LWR_LO = 8'h0c;
    localparam logic [7:0] A_LWR_HI = 8'h10;
    localparam logic [7:0] A_LDN_LO = 8'h14;
    localparam logic [7:0] A_LDN_HI = 8'h18;

    localparam int CTRL_EN    = 0;
    localparam int SR_BUSY    = 0;
    localparam int SR_WEL     = 1;
    localparam int SR_BP0     = 2;
    localparam int SR_TB      = 5;
    localparam int SR_SRWD    = 7;
    localparam int LK_WR      = 0;
    localparam int LK_DN      = 1;

    localparam logic       CTRL_EN_RST = 1'b1;
    localparam logic [2:0] BP_RST      = 3'h0;
    localparam logic       TB_RST      = 1'b0;
    localparam logic       SRWD_RST    = 1'b0;

    localparam logic [1:0] RES_NONE    = 2'h0;
    localparam logic [1:0] RES_DONE    = 2'h1;
    localparam logic [1:0] RES_REFUSED = 2'h2;

    localparam logic [3:0] SYNC_INIT = 4'h5;

    typedef enum logic [1:0] {ER_SUB, ER_SEC, ER_BULK} sfp_erase_kind_t;

    typedef struct packed {
        logic              we;
        logic              otp;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } sfp_arr_wr_t;

    typedef struct packed {
        logic              req;
        sfp_erase_kind_t   kind;
        logic [ADDR_W-1:0] addr;
    } sfp_erase_t;

    // sector count guarded by a protect code, then the side it grows from
    function automatic logic sfp_bp_hit(input logic tb, input logic [2:0] bp, input logic [SEC_W-1:0] sec);
        logic [6:0] n;
        n = (bp == 3'h0) ? 7'h00 : (bp == 3'h7) ? 7'h40 : (7'h01 << (bp - 3'h1));
        if (tb)
            return {1'b0, sec} < n;
        return {1'b0, sec} >= (7'h40 - n);
    endfunction : sfp_bp_hit
endpackage : sfp_pkg

/* logic/sfp_prot.sv */
// protection check of one sector and of the whole array
`timescale 1ns/1ns
`default_nettype none
module sfp_prot (
    input  wire logic                      tb,
    input  wire logic [2:0]                bp,
    input  wire logic [63:0]               lock_wr,
    input  wire logic [sfp_pkg::SEC_W-1:0] sec,
    output logic                           sec_prot,
    output logic                           any_prot
);
    import sfp_pkg::*;

    assign sec_prot = lock_wr[sec] | sfp_bp_hit(tb, bp, sec);
    // bulk erase refused when any sector is guarded
    assign any_prot = (bp != 3'h0) | (|lock_wr);
endmodule : sfp_prot
`default_nettype wire

/* logic/sfp_sync3.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module sfp_sync3 #(
    parameter int             W    = 1,
    parameter logic [W-1:0]   INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    import sfp_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sfp_sync_st_t;

    sfp_sync_st_t r_reg;
    sfp_sync_st_t r_next;

    // s1 is read only by s2; a level counts once s2 and s3 agree
    always_comb
    begin
        r_next    = r_reg;
        r_next.s1 = d;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        for (int i = 0; i < W; i++)
        begin
            if (r_reg.s2[i] == r_reg.s3[i])
                r_next.q[i] = r_reg.s3[i];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            r_reg <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
        else
            r_reg <= r_next;
    end

    assign q = r_reg.q;
endmodule : sfp_sync3
`default_nettype wire

/* logic/sfp_top.sv */
// serial command front end with write-protection checks and apb status
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module sfp_top (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 spi_clk,
    input  wire logic                 spi_sel_n,
    input  wire logic                 serial_data_in,
    output logic                      serial_data_out,
    output logic                      serial_data_oe,
    input  wire logic                 write_protect_n,
    input  wire logic [7:0]           arr_rdata,
    output sfp_pkg::sfp_arr_wr_t      arr_wr,
    output sfp_pkg::sfp_erase_t       erase,
    output logic                      busy
);
    import sfp_pkg::*;

    typedef struct packed {
        logic              clk_d;
        logic              sel;
        logic [2:0]        bitc;
        logic [9:0]        bytec;
        logic [7:0]        sh;
        logic [7:0]        op;
        logic [23:0]       addr;
        logic [7:0]        d0;
        logic [8:0]        nbuf;
        logic [7:0]        dout;
        logic              oe;
        logic              wel;
        logic [2:0]        bp;
        logic              tb;
        logic              srwd;
        logic [63:0]       lwr;
        logic [63:0]       ldn;
        logic              busy;
        logic              ph;
        logic              otp;
        logic [8:0]        idx;
        sfp_arr_wr_t       aw;
        sfp_erase_t        er;
        logic              en;
        logic [31:0]       rdata;
        logic              err;
        logic [1:0]        res;
        logic [7:0]        res_op;
        logic [15:0]       nref;
    } sfp_top_st_t;

    sfp_top_st_t r_reg;
    sfp_top_st_t r_next;

    logic [3:0]       sync_q;
    logic             clk_s;
    logic             seln_s;
    logic             din_s;
    logic             wp_s;
    logic             rise;
    logic             fall;
    logic             sel_now;
    logic             sec_prot;
    logic             any_prot;
    logic [7:0]       pbuf [PAGE_MAX];
    logic             buf_we;
    logic [7:0]       buf_idx;
    logic [7:0]       buf_data;
    logic [7:0]       b;
    logic [9:0]       kdat;
    logic [7:0]       sr_byte;
    logic             whole;
    logic             ok;
    logic             modify;
    logic [7:0]       lo8;
    logic [5:0]       lo6;

    ////////////////////////////////////////////////////////////////////////
    // pins into the pclk domain
    sfp_sync3 #(.W(4), .INIT(SYNC_INIT)) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({spi_clk, spi_sel_n, serial_data_in, write_protect_n}),
        .q     (sync_q)
    );

    assign {clk_s, seln_s, din_s, wp_s} = sync_q;
    // either idle level works since only edges are used
    assign rise = clk_s & ~r_reg.clk_d;
    assign fall = ~clk_s & r_reg.clk_d;
    // a new frame starts only while idle; a frame in progress runs to its end
    assign sel_now = ~seln_s & (r_reg.sel | (r_reg.en & ~r_reg.busy));

    // sector field of a 22-bit array address
    sfp_prot u_prot (
        .tb       (r_reg.tb),
        .bp       (r_reg.bp),
        .lock_wr  (r_reg.lwr),
        .sec      (r_reg.addr[SEC_LSB +: SEC_W]),
        .sec_prot (sec_prot),
        .any_prot (any_prot)
    );

    assign sr_byte = {r_reg.srwd, 1'b0, r_reg.tb, r_reg.bp, r_reg.wel, r_reg.busy};
    assign b       = {r_reg.sh[6:0], din_s};
    assign kdat    = r_reg.bytec - 10'h004;
    assign whole   = (r_reg.bitc == 3'h0);
    assign lo8     = r_reg.addr[7:0] + r_reg.idx[7:0];
    assign lo6     = r_reg.addr[5:0] + r_reg.idx[5:0];

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        r_next       = r_reg;
        r_next.clk_d = clk_s;
        r_next.aw.we = 1'b0;
        r_next.er    = '{req: 1'b0, kind: ER_SUB, addr: r_reg.er.addr};
        buf_we       = 1'b0;
        buf_idx      = kdat[7:0];
        buf_data     = b;
        ok           = 1'b0;
        modify       = 1'b0;

        // frame start clears the counters
        if (sel_now && !r_reg.sel)
        begin
            r_next.bitc  = 3'h0;
            r_next.bytec = 10'h000;
            r_next.nbuf  = 9'h000;
        end
        r_next.sel = sel_now;

        if (sel_now && r_reg.sel && rise)
        begin
            r_next.sh   = b;
            r_next.bitc = r_reg.bitc + 3'h1;
            if (r_reg.bitc == 3'h7)
            begin
                if (r_reg.bytec != 10'h3ff)
                    r_next.bytec = r_reg.bytec + 10'h001;
                if (r_reg.bytec == 10'h000)
                    r_next.op = b;
                else if (r_reg.bytec < 10'h004)
                    r_next.addr = {r_reg.addr[15:0], b};
                else
                begin
                    if (r_reg.bytec == 10'h004)
                        r_next.d0 = b;
                    // beyond one page the last 256 bytes are kept
                    if (r_reg.op == OP_PROG || r_reg.op == OP_OTPP)
                    begin
                        buf_we = 1'b1;
                        if (r_reg.nbuf != 9'h100)
                            r_next.nbuf = r_reg.nbuf + 9'h001;
                    end
                end
            end
        end

        // status readout shifts out on falling edges, repeating each byte
        if (sel_now && r_reg.sel && fall && r_reg.op == OP_RDSR && r_reg.bytec != 10'h000)
        begin
            r_next.oe   = 1'b1;
            r_next.dout = (r_reg.bitc == 3'h0) ? sr_byte : {r_reg.dout[6:0], 1'b0};
        end
        if (!sel_now)
            r_next.oe = 1'b0;

        // end of frame: decide
        if (r_reg.sel && !sel_now)
        begin
            case (r_reg.op)
                OP_WREN:
                begin
                    if (whole && r_reg.bytec == 10'h001)
                        r_next.wel = 1'b1;
                end
                OP_WRDI:
                begin
                    if (whole && r_reg.bytec == 10'h001)
                        r_next.wel = 1'b0;
                end
                OP_PROG, OP_OTPP:
                begin
                    modify = 1'b1;
                    // one-time area uses its own 6-bit space
                    if (r_reg.op == OP_OTPP)
                        ok = whole && r_reg.bytec >= 10'h005 && r_reg.wel
                             && r_reg.addr < 24'(OTP_BYTES);
                    else
                        ok = whole && r_reg.bytec >= 10'h005 && r_reg.wel && !sec_prot;
                    if (ok)
                    begin
                        r_next.busy = 1'b1;
                        r_next.ph   = 1'b0;
                        r_next.idx  = 9'h000;
                        r_next.otp  = (r_reg.op == OP_OTPP);
                    end
                end
                // no page erase opcode exists
                OP_SSE, OP_SE:
                begin
                    modify = 1'b1;
                    ok     = whole && r_reg.bytec == 10'h004 && r_reg.wel && !sec_prot;
                    r_next.er.req  = ok;
                    r_next.er.kind = (r_reg.op == OP_SSE) ? ER_SUB : ER_SEC;
                    r_next.er.addr = r_reg.addr[ADDR_W-1:0];
                end
                OP_BE:
                begin
                    modify = 1'b1;
                    ok     = whole && r_reg.bytec == 10'h001 && r_reg.wel && !any_prot;
                    r_next.er.req  = ok;
                    r_next.er.kind = ER_BULK;
                    r_next.er.addr = '0;
                end
                OP_WRSR:
                begin
                    modify = 1'b1;
                    // bit 7 plus a low pin freezes the protect fields
                    ok = whole && r_reg.bytec == 10'h002 && r_reg.wel
                         && !(r_reg.srwd && !wp_s);
                    if (ok)
                    begin
                        r_next.bp   = r_reg.addr[SR_BP0 +: 3];
                        r_next.tb   = r_reg.addr[SR_TB];
                        r_next.srwd = r_reg.addr[SR_SRWD];
                    end
                end
                OP_WRLR:
                begin
                    modify = 1'b1;
                    ok     = whole && r_reg.bytec == 10'h005 && r_reg.wel
                             && !r_reg.ldn[r_reg.addr[SEC_LSB +: SEC_W]];
                    if (ok)
                    begin
                        r_next.lwr[r_reg.addr[SEC_LSB +: SEC_W]] = r_reg.d0[LK_WR];
                        // lock-down only ever sets; reset alone clears it
                        r_next.ldn[r_reg.addr[SEC_LSB +: SEC_W]] = r_reg.d0[LK_DN];
                    end
                end
                default:
                begin
                    modify = 1'b0;
                end
            endcase
            if (modify)
            begin
                r_next.res_op = r_reg.op;
                r_next.res    = ok ? RES_DONE : RES_REFUSED;
                // refused: the latch keeps its value and the refusal count steps up
                if (ok)
                    r_next.wel = 1'b0;
                else if (r_reg.nref != 16'hffff)
                    r_next.nref = r_reg.nref + 16'h0001;
            end
        end

        // program walk: present address, then write old AND new
        if (r_reg.busy)
        begin
            if (!r_reg.ph)
            begin
                r_next.ph      = 1'b1;
                r_next.aw.otp  = r_reg.otp;
                r_next.aw.addr = r_reg.otp ? {16'h0000, lo6}
                                           : {r_reg.addr[ADDR_W-1:8], lo8};
            end
            else
            begin
                r_next.ph      = 1'b0;
                r_next.aw.we   = 1'b1;
                r_next.aw.data = arr_rdata & pbuf[r_reg.idx[7:0]];
                r_next.idx     = r_reg.idx + 9'h001;
                if (r_reg.idx + 9'h001 == r_reg.nbuf)
                    r_next.busy = 1'b0;
            end
        end

        // apb: read data latched in setup, writes in access
        if (psel && !penable)
        begin
            r_next.err = 1'b0;
            case (paddr)
                A_CTRL:   r_next.rdata = {31'h0000_0000, r_reg.en};
                A_STATUS: r_next.rdata = {24'h00_0000, sr_byte};
                A_RESULT: r_next.rdata = {r_reg.nref, r_reg.res_op, 6'h00, r_reg.res};
                A_LWR_LO: r_next.rdata = r_reg.lwr[31:0];
                A_LWR_HI: r_next.rdata = r_reg.lwr[63:32];
                A_LDN_LO: r_next.rdata = r_reg.ldn[31:0];
                A_LDN_HI: r_next.rdata = r_reg.ldn[63:32];
                default:
                begin
                    r_next.rdata = 32'h0000_0000;
                    r_next.err   = 1'b1;
                end
            endcase
        end
        if (psel && penable && pwrite && paddr == A_CTRL)
            r_next.en = pwdata[CTRL_EN];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_reg      <= '0;
            r_reg.clk_d <= SYNC_INIT[3];
            r_reg.bp   <= BP_RST;
            r_reg.tb   <= TB_RST;
            r_reg.srwd <= SRWD_RST;
            r_reg.en   <= CTRL_EN_RST;
            r_reg.res  <= RES_NONE;
        end
        else
            r_reg <= r_next;
    end

    // page buffer, no reset needed
    always_ff @(posedge pclk)
    begin
        if (buf_we)
            pbuf[buf_idx] <= buf_data;
    end

    assign prdata          = r_reg.rdata;
    assign pslverr         = r_reg.err;
    assign pready          = 1'b1;
    assign serial_data_out = r_reg.dout[7];
    assign serial_data_oe  = r_reg.oe & r_reg.sel;
    assign arr_wr          = r_reg.aw;
    assign erase           = r_reg.er;
    assign busy            = r_reg.busy;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_present;
        r_reg.busy && !r_reg.ph;
    endsequence
    sequence s_write;
        arr_wr.we && arr_wr.addr == $past(r_reg.aw.addr);
    endsequence

    property p_walk;
        s_present |=> !arr_wr.we ##1 s_write;
    endproperty
    a_walk: assert property (p_walk) else $error("program walk skipped a write");

    property p_clear_only;
        arr_wr.we |-> (arr_wr.data & ~$past(arr_rdata)) == 8'h00;
    endproperty
    a_clear_only: assert property (p_clear_only) else $error("program set a bit");

    property p_otp;
        arr_wr.we && arr_wr.otp |-> arr_wr.addr < 22'(OTP_BYTES);
    endproperty
    a_otp: assert property (p_otp) else $error("one-time write outside its area");

    property p_kind;
        erase.req |-> (erase.kind == ER_SUB && $past(r_reg.op) == OP_SSE)
            || (erase.kind == ER_SEC && $past(r_reg.op) == OP_SE)
            || (erase.kind == ER_BULK && $past(r_reg.op) == OP_BE);
    endproperty
    a_kind: assert property (p_kind) else $error("illegal erase size");

    property p_er_prot;
        erase.req |-> (erase.kind == ER_BULK) ? (r_reg.lwr == '0 && r_reg.bp == 3'h0)
            : !(r_reg.lwr[erase.addr[SEC_LSB +: SEC_W]] || sfp_bp_hit(r_reg.tb, r_reg.bp, erase.addr[SEC_LSB +: SEC_W]));
    endproperty
    a_er_prot: assert property (p_er_prot) else $error("erase of a guarded sector");

    property p_wel;
        erase.req |-> $past(r_reg.wel) && !r_reg.wel;
    endproperty
    a_wel: assert property (p_wel) else $error("erase without write enable");

    property p_whole;
        erase.req |-> $past(r_reg.bitc) == 3'h0;
    endproperty
    a_whole: assert property (p_whole) else $error("erase after partial byte");

    property p_ldn;
        ($past(r_reg.ldn) & ~r_reg.ldn) == '0;
    endproperty
    a_ldn: assert property (p_ldn) else $error("lock-down bit cleared");

    property p_frozen;
        ($past(r_reg.ldn) & ($past(r_reg.lwr) ^ r_reg.lwr)) == '0;
    endproperty
    a_frozen: assert property (p_frozen) else $error("locked-down write-lock changed");

    property p_sr_wp;
        $changed({r_reg.bp, r_reg.tb, r_reg.srwd}) |-> !$past(r_reg.srwd) || $past(wp_s);
    endproperty
    a_sr_wp: assert property (p_sr_wp) else $error("status written while frozen");

    property p_out_fall;
        serial_data_oe && $changed(serial_data_out) |-> $past(fall);
    endproperty
    a_out_fall: assert property (p_out_fall) else $error("output moved off a falling edge");

    property p_oe;
        !r_reg.sel |-> !r_reg.oe && !serial_data_oe;
    endproperty
    a_oe: assert property (p_oe) else $error("output driven while deselected");
endmodule : sfp_top
`default_nettype wire

/* sim/sfp_spi_host.sv */
// serial host model that clocks whole frames into the device
`timescale 1ns/1ns
`default_nettype none
module sfp_spi_host (
    output logic sclk,
    output logic sel_n,
    output logic mosi
);
    initial
    begin
        sclk = 1'b0;
        sel_n = 1'b1;
        mosi = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // clock stands at its idle level outside frames
    task automatic send(input logic [39:0] b, input int n, input logic pol);
        sclk = pol;
        #64 sel_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            sclk = 1'b0;
            mosi = b[39-i];
            #32 sclk = 1'b1;
            #32;
        end
        sclk = pol;
        #32 sel_n = 1'b1;
        mosi = ~mosi;
        #64;
    endtask : send
endmodule : sfp_spi_host
`default_nettype wire

/* sim/sfp_top_tb_top.sv */
// self-checking bench of the protection front end
`timescale 1ns/1ns
`default_nettype none
module sfp_top_tb_top;
    import sfp_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wp_n = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic        pready, pslverr, rerr, sdo, soe, busy, sclk, sel_n, mosi, pol = 1'b0;
    logic [7:0]  mem [0:255];
    logic [7:0]  rx;
    wire logic [7:0] arr_rdata;
    sfp_arr_wr_t arr_wr;
    sfp_erase_t  erase, last_er;
    int          fails = 0, n_tests = 0, cyc = 0, n_we = 0, n, s;
    sfp_top i_sfp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .spi_clk(sclk),
        .spi_sel_n(sel_n), .serial_data_in(mosi), .serial_data_out(sdo), .serial_data_oe(soe),
        .write_protect_n(wp_n), .arr_rdata(arr_rdata), .arr_wr(arr_wr), .erase(erase), .busy(busy));
    sfp_spi_host i_sfp_spi_host (.sclk(sclk), .sel_n(sel_n), .mosi(mosi));
    assign arr_rdata = mem[arr_wr.addr[7:0]];
    initial forever #4 pclk = ~pclk;
    // output bit settles well before the next falling clock
    always @(negedge sclk)
        if (!sel_n)
            rx <= {rx[6:0], sdo};
    ////////////////////////////////////////////////////////////////
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        n_we <= n_we + arr_wr.we;
        if (arr_wr.we)
            mem[arr_wr.addr[7:0]] <= arr_wr.data;
        if (erase.req)
            last_er <= erase;
        if (cyc == 50000)
        begin
            fails++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // no completion strobe for most commands: allow the sync delay, then busy
    // negedges keep pins off pclk edges and let the last array write land
    task automatic frame(input logic [39:0] b, input int nb);
        @(negedge pclk);
        i_sfp_spi_host.send(b, nb, pol);
        repeat (12) @(negedge pclk);
        while (busy !== 1'b0) @(negedge pclk);
        repeat (2) @(negedge pclk);
        check(soe, 1'b0);
    endtask : frame
    task automatic wen();
        frame({OP_WREN, 32'h0000_0000}, 8);
    endtask : wen
    task automatic res(input logic [1:0] e);
        apb(1'b0, A_RESULT, 32'h0000_0000);
        check(r[1:0], e);
    endtask : res
    task automatic report_and_stop();
        $display("tests=%0d mismatches=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'hf5;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, A_STATUS, 32'h0000_0000);
        check(r, 32'h0000_0000);
        apb(1'b0, 8'h1c, 32'h0000_0000);
        check({r[30:0], rerr}, 32'h0000_0001);
        apb(1'b0, A_CTRL, 32'h0000_0000);
        check(r, 32'h0000_0001);
        apb(1'b1, A_CTRL, 32'h0000_0000);
        wen();
        apb(1'b0, A_STATUS, 32'h0000_0000);
        check(r, 32'h0000_0000);
        apb(1'b1, A_CTRL, 32'h0000_0001);
        wen();
        apb(1'b0, A_STATUS, 32'h0000_0000);
        check(r[SR_WEL], 1'b1);
        frame({OP_RDSR, 32'h0000_0000}, 16);
        check(rx, 8'h02);
        frame({OP_WRDI, 32'h0000_0000}, 8);
        frame({OP_PROG, 24'h00_0010, 8'h0f}, 40);
        res(RES_REFUSED);
        wen();
        frame({OP_PROG, 24'h00_0010, 8'h0f}, 39);
        res(RES_REFUSED);
        check(n_we, 0);
        frame({OP_PROG, 24'h00_0010, 8'h0f}, 40);
        check(mem[8'h10], 8'h05);
        wen();
        frame({OP_OTPP, 24'h00_0040, 8'h00}, 40);
        res(RES_REFUSED);
        frame({OP_OTPP, 24'h00_0003, 8'h0f}, 40);
        check(mem[8'h03], 8'h05);
        wen();
        frame({OP_SSE, 24'h12_3456, 8'h00}, 32);
        check({last_er.kind, last_er.addr}, {ER_SUB, 22'h12_3456});
        $display("test program and erase done");
        // boundary sectors of every protect code, alternating clock modes
        for (int t = 0; t < 2; t++)
            for (int c = 0; c < 8; c++)
            begin
                n = (c == 0) ? 0 : (c == 7) ? 64 : 1 << (c - 1);
                pol = c[0];
                wen();
                frame({OP_WRSR, 2'h0, t[0], c[2:0], 2'h0, 24'h00_0000}, 16);
                for (int k = 0; k < 2; k++)
                begin
                    s = (t ? n - 1 + k : 64 - n - k) & 63;
                    wen();
                    frame({OP_SE, 2'h0, s[5:0], 24'h00_0000}, 32);
                    res((t ? s < n : s >= 64 - n) ? RES_REFUSED : RES_DONE);
                end
            end
        wen();
        frame({OP_WRSR, 32'h0000_0000}, 16);
        $display("test protect codes done");
        wen();
        frame({OP_WRLR, 24'h05_0000, 8'h01}, 40);
        wen();
        frame({OP_SE, 32'h0500_0000}, 32);
        res(RES_REFUSED);
        wen();
        frame({OP_WRLR, 24'h05_0000, 8'h03}, 40);
        wen();
        frame({OP_WRLR, 24'h05_0000, 8'h00}, 40);
        apb(1'b0, A_LWR_LO, 32'h0000_0000);
        check(r, 32'h0000_0020);
        apb(1'b0, A_LDN_LO, 32'h0000_0000);
        check(r, 32'h0000_0020);
        wen();
        frame({OP_BE, 32'h0000_0000}, 8);
        res(RES_REFUSED);
        $display("test sector locks done");
        wen();
        frame({OP_WRSR, 8'h80, 24'h00_0000}, 16);
        @(posedge pclk);
        wp_n <= 1'b0;
        wen();
        frame({OP_WRSR, 8'h04, 24'h00_0000}, 16);
        res(RES_REFUSED);
        apb(1'b0, A_STATUS, 32'h0000_0000);
        check(r[7:2], 6'h20);
        $display("test status guard done");
        report_and_stop();
    end
endmodule : sfp_top_tb_top
`default_nettype wire
